// [hdl/ssbc_pkg.sv]
// Shared constants and types for the sync-serial / bus-conflict channel
package ssbc_pkg;
	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] A_TXB  = 8'h00;
	localparam logic [7:0] A_RXB  = 8'h04;
	localparam logic [7:0] A_MODE = 8'h08;
	localparam logic [7:0] A_CTL0 = 8'h0c;
	localparam logic [7:0] A_CTL1 = 8'h10;
	localparam logic [7:0] A_SPM  = 8'h14;
	localparam logic [7:0] A_IRQ  = 8'h18;
	localparam logic [7:0] A_BRG  = 8'h1c;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int B_CLOCK_DIRECTION_SELECT  = 3;
	localparam int B_IO_POLARITY_INVERT  = 7;
	localparam int B_SHIFT_REGISTER_EMPTY_FLAG  = 3;
	localparam int B_HSDIS  = 4;
	localparam int B_ODRV   = 5;
	localparam int B_TE     = 0;
	localparam int B_TI     = 1;
	localparam int B_RE     = 2;
	localparam int B_RI     = 3;
	localparam int B_IRS    = 4;
	localparam int B_CKSTOP = 5;
	localparam int B_CONFLICT_SAMPLE_SELECT  = 4;
	localparam int B_AUTO_CLEAR_TX_ENABLE   = 5;
	localparam int B_SSS    = 6;
	localparam int B_CKDIV  = 7;
	localparam int B_CKSYNC = 8;
	localparam int B_ITX    = 0;
	localparam int B_IRX    = 1;
	localparam int B_IBC    = 2;
	localparam int B_RTA    = 4;
	localparam int B_RTB    = 5;

	// ****************************************
	// Reset values, modes, counts, answers
	// ****************************************
	localparam logic [7:0] R_CTL0    = 8'h08;
	localparam logic [7:0] R_CTL1    = 8'h02;
	localparam logic [2:0] R_PIN     = 3'h7;
	localparam logic [2:0] M_SYNC    = 3'h1;
	localparam logic [2:0] M_BUS     = 3'h6;
	localparam logic [3:0] C_SYNC_OV = 4'h6;
	localparam logic [3:0] C_SYNC_LS = 4'h7;
	localparam logic [3:0] C_BUS_STP = 4'h9;
	localparam logic [1:0] RESP_OK   = 2'h0;
	localparam logic [1:0] RESP_ERR  = 2'h2;

	typedef enum logic [0:0] {
		ST_IDLE  = 1'b0,
		ST_SHIFT = 1'b1
	} ssbc_st_t;
endpackage

// [hdl/ssbc_core.sv]
// Serial channel: clock-synchronised mode and 9-bit bus mode with conflict detect
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
module ssbc_core (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [7:0]  awaddr,
	// AXI4-Lite write data
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	// AXI4-Lite write response
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	// AXI4-Lite read address
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [7:0]  araddr,
	// AXI4-Lite read data
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// Serial pins
	input  wire logic        trigger_input_pin,
	input  wire logic        serial_clock_i,
	output logic             serial_clock_o,
	output logic             serial_clock_oe,
	input  wire logic        serial_in_pin,
	output logic             serial_out_o,
	output logic             serial_out_oe,
	input  wire logic        timer_underflow,
	// Interrupt requests
	output logic             tx_irq,
	output logic             rx_irq,
	output logic             conflict_irq_40,
	output logic             conflict_irq_41
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic                aw_got;
		logic [7:0]          awaddr;
		logic                w_got;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic [8:0]          tx_buf;
		logic [8:0]          rx_buf;
		logic                overrun_error_flag;
		logic                framing_error_flag;
		logic [7:0]          mode_r;
		logic [7:0]          ctl0;
		logic [7:0]          ctl1;
		logic [8:0]          spm;
		logic [7:0]          brg;
		logic [7:0]          irqr;
		logic [2:0]          ck_s;
		logic [2:0]          tr_s;
		logic [2:0]          rx_s;
		ssbc_pkg::ssbc_st_t  tx_st;
		ssbc_pkg::ssbc_st_t  rx_st;
		logic [3:0]          tx_cnt;
		logic [3:0]          rx_cnt;
		logic [8:0]          tx_sh;
		logic [8:0]          rx_sh;
		logic                tx_lvl;
		logic                div_ph;
		logic [7:0]          baud_cnt;
		logic                ick;
	} ssbc_state_t;

	ssbc_state_t q;
	ssbc_state_t d;

	// Readback word of one register; also the base for byte-lane merges
	function automatic logic [31:0] ssbc_rd(input ssbc_state_t s, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			ssbc_pkg::A_TXB:  r[8:0] = s.tx_buf;
			ssbc_pkg::A_RXB:  r[15:0] = {s.overrun_error_flag | s.framing_error_flag, 1'b0, s.framing_error_flag, s.overrun_error_flag, 3'h0, s.rx_buf};
			ssbc_pkg::A_MODE: r[7:0] = s.mode_r;
			ssbc_pkg::A_CTL0: r[7:0] = s.ctl0;
			ssbc_pkg::A_CTL1: r[7:0] = s.ctl1;
			ssbc_pkg::A_SPM:  r[8:0] = s.spm;
			ssbc_pkg::A_IRQ:  r[7:0] = s.irqr;
			ssbc_pkg::A_BRG:  r[7:0] = s.brg;
			default:          r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	function automatic logic ssbc_hit(input logic [7:0] a);
		logic h;
		h = 1'b0;
		case (a)
			ssbc_pkg::A_TXB, ssbc_pkg::A_RXB, ssbc_pkg::A_MODE, ssbc_pkg::A_CTL0,
			ssbc_pkg::A_CTL1, ssbc_pkg::A_SPM, ssbc_pkg::A_IRQ, ssbc_pkg::A_BRG: h = 1'b1;
			default: h = 1'b0;
		endcase
		return h;
	endfunction

	// ****************************************
	// Decoded controls and line events
	// ****************************************
	logic        is_sync;
	logic        is_bus;
	logic        inv;
	logic        te;
	logic        ti;
	logic        re;
	logic        ri;
	logic        irs;
	logic        ckdiv;
	logic        run;
	logic        ck_rise;
	logic        ck_fall;
	logic        tr_fall;
	logic        rx_lvl;
	logic        rx_fall;
	logic        dr;
	logic        df;
	logic        tick;
	logic        bc_pt;
	logic        sync_go;
	logic        bus_go;
	logic        tx_load;
	logic        line;
	logic [31:0] wmask;
	logic [31:0] wv;

	assign is_sync = q.mode_r[2:0] == ssbc_pkg::M_SYNC;
	assign is_bus  = q.mode_r[2:0] == ssbc_pkg::M_BUS;
	assign te      = q.ctl1[ssbc_pkg::B_TE];
	assign ti      = q.ctl1[ssbc_pkg::B_TI];
	assign re      = q.ctl1[ssbc_pkg::B_RE];
	assign ri      = q.ctl1[ssbc_pkg::B_RI];
	assign irs     = q.ctl1[ssbc_pkg::B_IRS];
	assign ckdiv   = q.spm[ssbc_pkg::B_CKDIV];
	// polarity only acts in bus mode
	assign inv     = is_bus & q.mode_r[ssbc_pkg::B_IO_POLARITY_INVERT];
	// edges are taken from the second and third stages only
	assign ck_rise = q.ck_s[1] & ~q.ck_s[2];
	assign ck_fall = ~q.ck_s[1] & q.ck_s[2];
	assign tr_fall = ~q.tr_s[1] & q.tr_s[2];
	assign rx_lvl  = q.rx_s[1] ^ inv;
	assign rx_fall = ~rx_lvl & (q.rx_s[2] ^ inv);

	// stop control freezes the derived clock mid-character
	assign run = (q.tx_st == ssbc_pkg::ST_SHIFT) & ~q.ctl1[ssbc_pkg::B_CKSTOP];
	// divide-by-2 uses alternate external rises as fall and rise
	assign df = is_sync & run & (ckdiv ? (ck_rise & ~q.div_ph) : ck_fall);
	assign dr = is_sync & run & (ckdiv ? (ck_rise & q.div_ph) : ck_rise);

	// bus bit clock: own baud rise or external pin rise
	assign tick = is_bus & (q.mode_r[ssbc_pkg::B_CLOCK_DIRECTION_SELECT] ? ck_rise
		: ((q.baud_cnt == q.brg) & ~q.ick));
	assign bc_pt = q.spm[ssbc_pkg::B_CONFLICT_SAMPLE_SELECT] ? timer_underflow : tick;

	// trigger only starts a loaded, enabled transfer
	assign sync_go = is_sync & q.ctl0[ssbc_pkg::B_HSDIS] & tr_fall & te & re & ~ti;
	// optional start on serial input falling edge
	assign bus_go  = is_bus & te & ~ti & (q.spm[ssbc_pkg::B_SSS] ? rx_fall : tick);
	assign tx_load = (q.tx_st == ssbc_pkg::ST_IDLE) & (sync_go | bus_go);

	// Byte-lane merge of a pending write over the current contents
	assign wmask = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
	assign wv    = (ssbc_rd(q, q.awaddr) & ~wmask) | (q.wdata & wmask);

	// ****************************************
	// Next-state logic
	// ****************************************
	// Software clears come first so that hardware sets later win
	always_comb begin
		d = q;
		// two-stage synchronisers plus an edge stage
		d.ck_s = {q.ck_s[1:0], serial_clock_i};
		d.tr_s = {q.tr_s[1:0], trigger_input_pin};
		d.rx_s = {q.rx_s[1:0], serial_in_pin};

		// Write channel: address and data in either order
		if (awvalid && awready) begin
			d.aw_got = 1'b1;
			d.awaddr = awaddr;
		end
		if (wvalid && wready) begin
			d.w_got = 1'b1;
			d.wdata = wdata;
			d.wstrb = wstrb;
		end
		if (q.bvalid && bready) begin
			d.bvalid = 1'b0;
		end
		if (q.aw_got && q.w_got) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = ssbc_hit(q.awaddr) ? ssbc_pkg::RESP_OK : ssbc_pkg::RESP_ERR;
			case (q.awaddr)
				ssbc_pkg::A_TXB: begin
					d.tx_buf = wv[8:0];
					d.ctl1[ssbc_pkg::B_TI] = 1'b0;
				end
				ssbc_pkg::A_MODE: d.mode_r = wv[7:0];
				ssbc_pkg::A_CTL0: d.ctl0 = {wv[7:4], q.ctl0[3], wv[2:0]};
				ssbc_pkg::A_CTL1: d.ctl1 = {wv[7:4], q.ctl1[3], wv[2], q.ctl1[1], wv[0]};
				ssbc_pkg::A_SPM:  d.spm = wv[8:0];
				ssbc_pkg::A_BRG:  d.brg = wv[7:0];
				// Flags clear by writing one; routes are plain bits
				ssbc_pkg::A_IRQ:  d.irqr = {wv[7:3], q.irqr[2:0] & ~(q.wdata[2:0] & wmask[2:0])};
				default: d.bresp = ssbc_pkg::RESP_ERR;
			endcase
		end

		// Read channel; reading the receive buffer releases it
		if (q.rvalid && rready) begin
			d.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			d.rvalid = 1'b1;
			d.rdata  = ssbc_rd(q, araddr);
			d.rresp  = ssbc_hit(araddr) ? ssbc_pkg::RESP_OK : ssbc_pkg::RESP_ERR;
			if (araddr == ssbc_pkg::A_RXB) begin
				d.ctl1[ssbc_pkg::B_RI] = 1'b0;
				d.overrun_error_flag = 1'b0;
				d.framing_error_flag = 1'b0;
			end
		end

		// Internal baud clock, driven out on the clock pin; idles high
		if (is_bus && !q.mode_r[ssbc_pkg::B_CLOCK_DIRECTION_SELECT]) begin
			if (q.baud_cnt == q.brg) begin
				d.baud_cnt = 8'h00;
				d.ick = ~q.ick;
			end else begin
				d.baud_cnt = q.baud_cnt + 8'h01;
			end
		end else begin
			d.baud_cnt = 8'h00;
			d.ick = 1'b1;
		end

		// Transmit side, and receive side of the sync mode
		if (tx_load) begin
			d.tx_st  = ssbc_pkg::ST_SHIFT;
			d.tx_cnt = 4'h0;
			d.div_ph = 1'b0;
			d.tx_sh  = q.tx_buf;
			d.ctl1[ssbc_pkg::B_TI] = 1'b1;
			d.ctl0[ssbc_pkg::B_SHIFT_REGISTER_EMPTY_FLAG] = 1'b0;
			// Bus mode opens with the start bit at once
			if (is_bus) begin
				d.tx_lvl = 1'b0;
			end
			if (!irs) begin
				d.irqr[ssbc_pkg::B_ITX] = 1'b1;
			end
		end else if (q.tx_st == ssbc_pkg::ST_SHIFT && is_sync) begin
			if (run && ck_rise && ckdiv) begin
				d.div_ph = ~q.div_ph;
			end
			// bit out on derived fall, LSB first
			if (df) begin
				d.tx_lvl = q.tx_sh[0];
				d.tx_sh  = {1'b0, q.tx_sh[8:1]};
			end
			if (dr) begin
				d.tx_cnt = q.tx_cnt + 4'h1;
				d.rx_sh  = {1'b0, rx_lvl, q.rx_sh[7:1]};
				// seventh bit in while the buffer is still unread
				if (q.tx_cnt == ssbc_pkg::C_SYNC_OV && ri) begin
					d.overrun_error_flag = 1'b1;
				end
				if (q.tx_cnt == ssbc_pkg::C_SYNC_LS) begin
					d.tx_st  = ssbc_pkg::ST_IDLE;
					d.tx_lvl = 1'b1;
					d.ctl0[ssbc_pkg::B_SHIFT_REGISTER_EMPTY_FLAG] = 1'b1;
					if (irs) begin
						d.irqr[ssbc_pkg::B_ITX] = 1'b1;
					end
					if (re && !ri) begin
						d.rx_buf = {1'b0, rx_lvl, q.rx_sh[7:1]};
						d.ctl1[ssbc_pkg::B_RI] = 1'b1;
						d.irqr[ssbc_pkg::B_IRX] = 1'b1;
					end
				end
			end
		end else if (q.tx_st == ssbc_pkg::ST_SHIFT && is_bus) begin
			// start, nine data bits, one stop bit
			if (tick) begin
				d.tx_cnt = q.tx_cnt + 4'h1;
				if (q.tx_cnt < ssbc_pkg::C_BUS_STP) begin
					d.tx_lvl = q.tx_sh[0];
					d.tx_sh  = {1'b0, q.tx_sh[8:1]};
				end else if (q.tx_cnt == ssbc_pkg::C_BUS_STP) begin
					d.tx_lvl = 1'b1;
				end else begin
					d.tx_st = ssbc_pkg::ST_IDLE;
					d.ctl0[ssbc_pkg::B_SHIFT_REGISTER_EMPTY_FLAG] = 1'b1;
					if (irs) begin
						d.irqr[ssbc_pkg::B_ITX] = 1'b1;
					end
				end
			end
		end else if (q.tx_st == ssbc_pkg::ST_SHIFT) begin
			// Mode changed under a running character: abandon it
			d.tx_st  = ssbc_pkg::ST_IDLE;
			d.tx_lvl = 1'b1;
			d.ctl0[ssbc_pkg::B_SHIFT_REGISTER_EMPTY_FLAG] = 1'b1;
		end

		// bus-mode receiver, sampled once per bit clock
		if (!is_bus) begin
			d.rx_st = ssbc_pkg::ST_IDLE;
		end else if (tick && q.rx_st == ssbc_pkg::ST_IDLE) begin
			if (re && !rx_lvl) begin
				d.rx_st  = ssbc_pkg::ST_SHIFT;
				d.rx_cnt = 4'h0;
			end
		end else if (tick) begin
			d.rx_cnt = q.rx_cnt + 4'h1;
			if (q.rx_cnt < ssbc_pkg::C_BUS_STP) begin
				d.rx_sh = {rx_lvl, q.rx_sh[8:1]};
			end else begin
				d.rx_st = ssbc_pkg::ST_IDLE;
				if (!rx_lvl) begin
					d.framing_error_flag = 1'b1;
				end
				// an unread buffer keeps its old word
				if (ri) begin
					d.overrun_error_flag = 1'b1;
				end else begin
					d.rx_buf = q.rx_sh;
					d.ctl1[ssbc_pkg::B_RI] = 1'b1;
					d.irqr[ssbc_pkg::B_IRX] = 1'b1;
				end
			end
		end

		if (is_bus && q.tx_st == ssbc_pkg::ST_SHIFT && bc_pt && (q.tx_lvl != rx_lvl)) begin
			d.irqr[ssbc_pkg::B_IBC] = 1'b1;
		end
		// auto-clear overrides any software write of TE
		if (q.spm[ssbc_pkg::B_AUTO_CLEAR_TX_ENABLE] && q.irqr[ssbc_pkg::B_IBC]) begin
			d.ctl1[ssbc_pkg::B_TE] = 1'b0;
		end
	end

	// State register; pins idle high after reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q        <= '0;
			q.ctl0   <= ssbc_pkg::R_CTL0;
			q.ctl1   <= ssbc_pkg::R_CTL1;
			q.ck_s   <= ssbc_pkg::R_PIN;
			q.tr_s   <= ssbc_pkg::R_PIN;
			q.rx_s   <= ssbc_pkg::R_PIN;
			q.tx_lvl <= 1'b1;
			q.ick    <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Bus handshakes; one write and one read in flight
	assign awready = ~q.aw_got & ~q.bvalid;
	assign wready  = ~q.w_got & ~q.bvalid;
	assign arready = ~q.rvalid;
	assign bvalid  = q.bvalid;
	assign bresp   = q.bresp;
	assign rvalid  = q.rvalid;
	assign rdata   = q.rdata;
	assign rresp   = q.rresp;

	assign line            = q.tx_lvl ^ inv;
	assign serial_out_o    = q.ctl0[ssbc_pkg::B_ODRV] ? 1'b0 : line;
	assign serial_out_oe   = q.ctl0[ssbc_pkg::B_ODRV] ? ~line : 1'b1;
	assign serial_clock_o  = q.ick;
	assign serial_clock_oe = is_bus & ~q.mode_r[ssbc_pkg::B_CLOCK_DIRECTION_SELECT];

	// conflict request steered by the two route bits
	assign tx_irq          = q.irqr[ssbc_pkg::B_ITX];
	assign rx_irq          = q.irqr[ssbc_pkg::B_IRX];
	assign conflict_irq_40 = q.irqr[ssbc_pkg::B_IBC] & q.irqr[ssbc_pkg::B_RTA];
	assign conflict_irq_41 = q.irqr[ssbc_pkg::B_IBC] & q.irqr[ssbc_pkg::B_RTB];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_start_cond;
		tx_load |-> (te && !ti && (is_bus || (re && tr_fall)));
	endproperty
	a_start_cond: assert property (p_start_cond) else $error("start without conditions");

	property p_txirq_load;
		(tx_load && !irs) |=> (tx_irq && ti);
	endproperty
	a_txirq_load: assert property (p_txirq_load) else $error("no tx request at load");

	property p_sync_store;
		(dr && q.tx_cnt == ssbc_pkg::C_SYNC_LS && re && !ri) |=> (rx_irq && ri && q.tx_st == ssbc_pkg::ST_IDLE);
	endproperty
	a_sync_store: assert property (p_sync_store) else $error("rx store missed");

	property p_sync_len;
		(dr && q.tx_cnt == ssbc_pkg::C_SYNC_LS) |=> q.ctl0[ssbc_pkg::B_SHIFT_REGISTER_EMPTY_FLAG];
	endproperty
	a_sync_len: assert property (p_sync_len) else $error("sync char not eight bits");

	property p_overrun;
		(dr && q.tx_cnt == ssbc_pkg::C_SYNC_OV && ri) |=> q.overrun_error_flag;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_ovr_keep;
		(dr && q.tx_cnt == ssbc_pkg::C_SYNC_LS && ri && !(arvalid && arready)) |=> $stable(q.rx_buf);
	endproperty
	a_ovr_keep: assert property (p_ovr_keep) else $error("overrun char stored");

	property p_div2;
		(q.tx_st == ssbc_pkg::ST_SHIFT && is_sync && ckdiv && run && ck_rise) |=> (q.div_ph != $past(q.div_ph));
	endproperty
	a_div2: assert property (p_div2) else $error("divide phase stuck");

	property p_clk_stop;
		(q.ctl1[ssbc_pkg::B_CKSTOP] && is_sync && q.tx_st == ssbc_pkg::ST_SHIFT)
			|=> ($stable(q.tx_cnt) && $stable(q.tx_lvl));
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("clock ran while stopped");

	property p_conflict;
		(is_bus && q.tx_st == ssbc_pkg::ST_SHIFT && bc_pt && q.tx_lvl != rx_lvl) |=> q.irqr[ssbc_pkg::B_IBC];
	endproperty
	a_conflict: assert property (p_conflict) else $error("conflict missed");

	property p_autoclr;
		(q.spm[ssbc_pkg::B_AUTO_CLEAR_TX_ENABLE] && q.irqr[ssbc_pkg::B_IBC]) |=> !te;
	endproperty
	a_autoclr: assert property (p_autoclr) else $error("TE not cleared");

	property p_sss;
		(is_bus && q.spm[ssbc_pkg::B_SSS] && te && !ti && q.tx_st == ssbc_pkg::ST_IDLE && rx_fall)
			|=> (q.tx_st == ssbc_pkg::ST_SHIFT && !q.tx_lvl);
	endproperty
	a_sss: assert property (p_sss) else $error("rx-synced start missed");

	property p_odrain;
		q.ctl0[ssbc_pkg::B_ODRV] |-> (!serial_out_o && (serial_out_oe == !(q.tx_lvl ^ inv)));
	endproperty
	a_odrain: assert property (p_odrain) else $error("open drain drives high");

	c_sync_char: cover property (dr && q.tx_cnt == ssbc_pkg::C_SYNC_LS);
	c_bus_conf: cover property (is_bus && bc_pt && q.tx_st == ssbc_pkg::ST_SHIFT && q.tx_lvl != rx_lvl);
	c_bus_rx: cover property (is_bus && tick && q.rx_st == ssbc_pkg::ST_SHIFT && q.rx_cnt == ssbc_pkg::C_BUS_STP);
endmodule

// [bench/ssbc_partner.sv]
// Behavioural model of the external serial node on the far side of the channel
module ssbc_partner (
	// Device line outputs
	input  wire logic tx_o,
	input  wire logic tx_oe,
	// Scenario controls
	input  wire logic loop,
	input  wire logic jam,
	// Pins towards the device
	output logic      clk_pin,
	output logic      trig_n,
	output logic      rx_line
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       sdat;
	logic [7:0] got;

	// shared bus with pull-up, a jamming node pulls it low
	assign rx_line = loop ? (jam ? 1'b0 : (tx_oe ? tx_o : 1'b1)) : sdat;

	// Clock idles high between frames, as a start needs
	initial begin
		clk_pin = 1'b1;
		trig_n  = 1'b1;
		sdat    = 1'b1;
	end

	// one trigger pulse, held low for 82 ns, whether or not the device is armed
	task automatic trig();
		#1;
		trig_n = 1'b0;
		#82;
		trig_n = 1'b1;
		#83;
	endtask

	// eight bits LSB first, data on fall, sampled on rise
	task automatic clocks(logic [7:0] p, int hp);
		// Step off the device's clock edge before the first fall
		#1;
		for (int i = 0; i < 8; i++) begin
			clk_pin = 1'b0;
			sdat = p[i];
			#hp;
			clk_pin = 1'b1;
			got[i] = tx_oe ? tx_o : 1'b1;
			#hp;
		end
		// Hold time over: show the inverse, never the last bit
		sdat = ~p[7];
	endtask
endmodule

// [bench/sync_serial_bus_conflict_test.sv]
// Self-checking bench for the sync-serial and bus-conflict channel
module sync_serial_bus_conflict_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, clk_pin, clk_w, trig_n, rx_line;
	logic        so_o, so_oe, ck_o, ck_oe, tx_irq, rx_irq, irq40, irq41, loop, jam, tmr_uf;
	logic [7:0]  awaddr, araddr, px;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic [8:0]  v;
	int          err_count, checks_done, n;

	always #2 aclk = ~aclk;
	// Clock pin: device drives it only with the internal clock
	assign clk_w = ck_oe ? ck_o : clk_pin;

	ssbc_core ssbc_core_i (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
		.trigger_input_pin(trig_n), .serial_clock_i(clk_w), .serial_clock_o(ck_o), .serial_clock_oe(ck_oe),
		.serial_in_pin(rx_line), .serial_out_o(so_o), .serial_out_oe(so_oe), .timer_underflow(tmr_uf),
		.tx_irq, .rx_irq, .conflict_irq_40(irq40), .conflict_irq_41(irq41));
	ssbc_partner ssbc_partner_i (.tx_o(so_o), .tx_oe(so_oe), .loop, .jam, .clk_pin, .trig_n, .rx_line);

	// ****************************************
	// Bus cycles and comparisons
	// ****************************************
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Half-rate sync: only every second external rise samples a bit
	function automatic logic [7:0] half_rate(logic [7:0] a, logic [7:0] b);
		return {b[7], b[5], b[3], b[1], a[7], a[5], a[3], a[1]};
	endfunction

	// Handshakes sampled at the falling edge, so the rising edge sees the same values
	task automatic wr(logic [7:0] a, logic [31:0] x, logic [1:0] er = ssbc_pkg::RESP_OK);
		logic       ta, tw, tb;
		logic [1:0] r;
		awaddr <= a;
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		chk("bresp", er, r);
	endtask

	task automatic rd(logic [7:0] a, logic [1:0] er = ssbc_pkg::RESP_OK);
		logic       ta, tr;
		logic [1:0] r;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end while (!tr);
		chk("rresp", er, r);
	endtask

	// One clock-synchronised frame from the far side
	task automatic sframe(logic [7:0] p, logic ex);
		ssbc_partner_i.trig();
		repeat (6) @(posedge aclk);
		chk("tx_irq at load", ex, tx_irq);
		ssbc_partner_i.clocks(p, 41);
		repeat (6) @(posedge aclk);
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		bready = 1'b1;
		rready = 1'b1;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		loop = 1'b0;
		jam = 1'b0;
		tmr_uf = 1'b0;
		err_count = 0;
		checks_done = 0;
		n = $urandom(46847);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(ssbc_pkg::A_CTL0);
		chk("ctl0 reset", 32'(ssbc_pkg::R_CTL0), d);
		rd(ssbc_pkg::A_CTL1);
		chk("ctl1 reset", 32'(ssbc_pkg::R_CTL1), d);
		rd(8'h20, ssbc_pkg::RESP_ERR);
		wr(8'h20, 32'h1, ssbc_pkg::RESP_ERR);
		$display("reset test done");
		// sync mode, external clock, handshake off
		wr(ssbc_pkg::A_MODE, 32'(ssbc_pkg::M_SYNC) | (32'h1 << ssbc_pkg::B_CLOCK_DIRECTION_SELECT));
		wr(ssbc_pkg::A_CTL0, 32'h1 << ssbc_pkg::B_HSDIS);
		for (int k = 0; k < 2; k++) begin
			wr(ssbc_pkg::A_CTL1, 32'h5 | (k << ssbc_pkg::B_IRS));
			wr(ssbc_pkg::A_IRQ, 32'h7);
			v = 9'($urandom);
			px = 8'($urandom);
			wr(ssbc_pkg::A_TXB, 32'(v));
			rd(ssbc_pkg::A_CTL1);
			chk("buffer loaded", 0, d[ssbc_pkg::B_TI]);
			sframe(px, k == 0);
			chk("rx_irq", 1, rx_irq);
			chk("tx_irq", 1, tx_irq);
			chk("sent bits", 32'(v[7:0]), 32'(ssbc_partner_i.got));
			rd(ssbc_pkg::A_CTL1);
			chk("rx complete", 1, d[ssbc_pkg::B_RI]);
			if (k == 0) begin
				// Second frame while the first is unread
				wr(ssbc_pkg::A_IRQ, 32'h7);
				wr(ssbc_pkg::A_TXB, 32'(v));
				sframe(~px, 1'b1);
				chk("no rx_irq", 0, rx_irq);
				rd(ssbc_pkg::A_RXB);
				chk("overrun", 1, d[12]);
			end else begin
				rd(ssbc_pkg::A_RXB);
				chk("rx data", 32'(px), 32'(d[7:0]));
			end
		end
		// a stopped clock holds the character; then runs it at half rate
		wr(ssbc_pkg::A_SPM, 32'h1 << ssbc_pkg::B_CKDIV);
		wr(ssbc_pkg::A_CTL1, 32'h25);
		wr(ssbc_pkg::A_IRQ, 32'h7);
		wr(ssbc_pkg::A_TXB, 32'(v));
		sframe(px, 1'b1);
		rd(ssbc_pkg::A_CTL0);
		chk("held by clock stop", 0, d[ssbc_pkg::B_SHIFT_REGISTER_EMPTY_FLAG]);
		chk("no rx while stopped", 0, rx_irq);
		wr(ssbc_pkg::A_CTL1, 32'h5);
		ssbc_partner_i.clocks(px, 41);
		@(posedge aclk);
		rd(ssbc_pkg::A_CTL0);
		chk("half char at half rate", 0, d[ssbc_pkg::B_SHIFT_REGISTER_EMPTY_FLAG]);
		ssbc_partner_i.clocks(v[7:0], 41);
		@(posedge aclk);
		rd(ssbc_pkg::A_RXB);
		chk("half rate data", 32'(half_rate(px, v[7:0])), 32'(d[7:0]));
		chk("half rate done", 1, rx_irq);
		$display("sync test done");
		// bus mode, internal clock, auto-clear on conflict
		wr(ssbc_pkg::A_BRG, 32'h1);
		wr(ssbc_pkg::A_MODE, 32'(ssbc_pkg::M_BUS));
		wr(ssbc_pkg::A_SPM, 32'h1 << ssbc_pkg::B_AUTO_CLEAR_TX_ENABLE);
		wr(ssbc_pkg::A_IRQ, 32'h17);
		loop <= 1'b1;
		jam <= 1'b1;
		wr(ssbc_pkg::A_CTL1, 32'h5);
		wr(ssbc_pkg::A_TXB, 32'h1ff);
		n = 0;
		while (!irq40 && n < 400) begin
			@(posedge aclk);
			n++;
		end
		chk("conflict 40", 1, irq40);
		chk("conflict 41", 0, irq41);
		chk("clock pin driven", 1, ck_oe);
		rd(ssbc_pkg::A_CTL1);
		chk("te cleared", 0, d[ssbc_pkg::B_TE]);
		// timer-paced compare, routed to the second line
		wr(ssbc_pkg::A_SPM, (32'h1 << ssbc_pkg::B_AUTO_CLEAR_TX_ENABLE) | (32'h1 << ssbc_pkg::B_CONFLICT_SAMPLE_SELECT));
		wr(ssbc_pkg::A_IRQ, 32'h27);
		wr(ssbc_pkg::A_CTL1, 32'h5);
		wr(ssbc_pkg::A_TXB, 32'h1ff);
		n = 0;
		while (!tx_irq && n < 400) begin
			@(posedge aclk);
			n++;
		end
		chk("tx_irq at bus load", 1, tx_irq);
		repeat (8) @(posedge aclk);
		chk("no compare without timer", 0, irq41);
		tmr_uf <= 1'b1;
		@(posedge aclk);
		tmr_uf <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("route b conflict", 1, irq41);
		chk("route a off", 0, irq40);
		wr(ssbc_pkg::A_SPM, 32'h1 << ssbc_pkg::B_AUTO_CLEAR_TX_ENABLE);
		jam <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			// Polarity inverted on pass 1, open drain on pass 2
			wr(ssbc_pkg::A_MODE, 32'(ssbc_pkg::M_BUS) | (32'(i == 1) << ssbc_pkg::B_IO_POLARITY_INVERT));
			wr(ssbc_pkg::A_CTL0, 32'h10 | (32'(i == 2) << ssbc_pkg::B_ODRV));
			// Let line settle: a polarity change can look like a start bit
			repeat (100) @(posedge aclk);
			rd(ssbc_pkg::A_RXB);
			wr(ssbc_pkg::A_IRQ, 32'h17);
			chk("idle drive", {i != 2, i == 0}, {so_oe, so_o});
			v = 9'($urandom);
			wr(ssbc_pkg::A_CTL1, 32'h5);
			wr(ssbc_pkg::A_TXB, 32'(v));
			n = 0;
			while (!rx_irq && n < 400) begin
				@(posedge aclk);
				n++;
			end
			chk("bus rx done", 1, rx_irq);
			rd(ssbc_pkg::A_RXB);
			chk("bus data", 32'(v), 32'(d[8:0]));
			chk("framing", 0, d[13]);
			chk("no conflict", 0, irq40);
		end
		// a loaded character waits for a falling edge on the line
		wr(ssbc_pkg::A_SPM, (32'h1 << ssbc_pkg::B_AUTO_CLEAR_TX_ENABLE) | (32'h1 << ssbc_pkg::B_SSS));
		wr(ssbc_pkg::A_TXB, 32'(v));
		repeat (20) @(posedge aclk);
		rd(ssbc_pkg::A_CTL0);
		chk("waits for line fall", 1, d[ssbc_pkg::B_SHIFT_REGISTER_EMPTY_FLAG]);
		jam <= 1'b1;
		@(posedge aclk);
		jam <= 1'b0;
		repeat (4) @(posedge aclk);
		rd(ssbc_pkg::A_CTL0);
		chk("starts on line fall", 0, d[ssbc_pkg::B_SHIFT_REGISTER_EMPTY_FLAG]);
		$display("bus test done");
		results();
	end

	// Watchdog well beyond the expected run
	initial begin
		#300000;
		err_count++;
		results();
	end
endmodule
